// ---- hdl/t1cfg_pkg.sv ----
// Constants for the transmit and global configuration register bank
package t1cfg_pkg;
	localparam int LINKS = 8;
	localparam int DW = 8;
	localparam int AW = 11;
	localparam int MAPS = 12;
	localparam int GAP_W = 7;
	localparam int LINK_LSB = 8;
	localparam int LINK_MSB = 10;
	localparam int MAP_W = LINKS * MAPS * DW;
	localparam logic [7:0] OFS_WIN_SEL = 8'h0E;
	localparam logic [7:0] OFS_WIN_DATA = 8'h0F;
	localparam logic [7:0] OFS_BACKPLANE = 8'h10;
	localparam logic [7:0] OFS_JA_CFG = 8'h21;
	localparam logic [7:0] OFS_TX_A = 8'h22;
	localparam logic [7:0] OFS_TX_B = 8'h23;
	localparam logic [7:0] OFS_GAP_IND = 8'h38;
	localparam int WIN_LINK_MSB = 7;
	localparam int WIN_LINK_LSB = 5;
	localparam int WIN_IDX_MSB = 3;
	localparam int BP_RX_SHARED = 4;
	localparam int BP_RX_MUX = 3;
	localparam int BP_TX_BUS = 2;
	localparam int BP_TX_SHARED = 1;
	localparam int BP_TX_MUX = 0;
	localparam int JA_MEASURE = 5;
	localparam int JA_LIMIT = 4;
	localparam int JA_EN = 3;
	localparam int JA_DEPTH_MSB = 2;
	localparam int JA_DEPTH_LSB = 1;
	localparam int JA_CORNER = 0;
	localparam int TXA_OFF = 4;
	localparam int TXA_CODE = 0;
	localparam int TXB_WATCH = 5;
	localparam int TXB_FLOAT = 4;
	localparam int TXB_PULSE_MSB = 3;
	localparam logic [7:0] WIN_SEL_MASK = 8'hEF;
	localparam logic [7:0] BP_MASK = 8'h1F;
	localparam logic [7:0] JA_MASK = 8'h3F;
	localparam logic [7:0] TXA_MASK = 8'h11;
	localparam logic [7:0] TXB_MASK = 8'h3F;
	localparam logic [7:0] WIN_SEL_RST = 8'h00;
	localparam logic [7:0] BP_RST = 8'h16;
	localparam logic [7:0] JA_RST = 8'h00;
	localparam logic [7:0] TXA_RST = 8'h00;
	localparam logic [7:0] TXB_RST = 8'h10;
	localparam logic [3:0] MAP_LAST = 4'hB;
	localparam logic [1:0] DEPTH_128 = 2'h0;
	localparam logic [1:0] DEPTH_64 = 2'h1;
	localparam logic [7:0] DEPTH_128_BITS = 8'h80;
	localparam logic [7:0] DEPTH_64_BITS = 8'h40;
	localparam logic [7:0] DEPTH_32_BITS = 8'h20;
	localparam logic [7:0] EDGE_128 = 8'h04;
	localparam logic [7:0] EDGE_64 = 8'h03;
	localparam logic [7:0] EDGE_32 = 8'h02;
	localparam logic [3:0] PULSE_SH_FIRST = 4'h2;
	localparam logic [3:0] PULSE_SH_LAST = 4'h6;
	localparam logic [3:0] PULSE_LH_FIRST = 4'h9;
	localparam logic [3:0] PULSE_LH_LAST = 4'hB;
	localparam logic [1:0] PULSE_ARB_TOP = 2'h3;
	typedef enum logic [1:0] {
		T1CFG_PULSE_RESERVED,
		T1CFG_PULSE_SHORT,
		T1CFG_PULSE_LONG,
		T1CFG_PULSE_ARB
	} t1cfg_pulse_e;
endpackage

// ---- hdl/t1cfg_counter_window.sv ----
// Indirect counter map selector
`timescale 1ns/100ps
module t1cfg_counter_window
	import t1cfg_pkg::*;
(
	input wire logic [2:0] link_pick_i,
	input wire logic [3:0] index_i,
	input wire logic [MAP_W-1:0] counter_map_i,
	output logic [DW-1:0] data_o
);
	logic [9:0] base;
	always_comb begin
		base = 10'((10'(link_pick_i) * 10'(MAPS) + 10'(index_i)) * 10'(DW));
		if (index_i > MAP_LAST) begin
			data_o = '0;
		end else begin
			data_o = counter_map_i[base +: DW];
		end
	end
endmodule

// ---- hdl/t1cfg_jitter_track.sv ----
// Per-link transmit attenuator pointer gap tracker
`timescale 1ns/100ps
module t1cfg_jitter_track
	import t1cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [GAP_W-1:0] gap_i,
	input wire logic measure_mode_i,
	input wire logic limit_i,
	input wire logic [1:0] depth_code_i,
	output logic [GAP_W-1:0] indication_o,
	output logic widen_o,
	output logic [7:0] depth_bits_o
);
	logic [7:0] depth_next;
	logic [7:0] edge_w;
	logic near;
	always_comb begin
		case (depth_code_i)
			DEPTH_128: begin
				depth_next = DEPTH_128_BITS;
				edge_w = EDGE_128;
			end
			DEPTH_64: begin
				depth_next = DEPTH_64_BITS;
				edge_w = EDGE_64;
			end
			default: begin
				depth_next = DEPTH_32_BITS;
				edge_w = EDGE_32;
			end
		endcase
		near = ({1'b0, gap_i} <= edge_w) ||
			(8'({1'b0, gap_i} + edge_w) >= depth_next);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			indication_o <= '0;
		end else if (measure_mode_i) begin
			if (gap_i > indication_o) begin
				indication_o <= gap_i;
			end
		end else begin
			indication_o <= gap_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			widen_o <= 1'b0;
			depth_bits_o <= DEPTH_128_BITS;
		end else begin
			widen_o <= limit_i & near;
			depth_bits_o <= depth_next;
		end
	end
endmodule

// ---- hdl/t1cfg_regs.sv ----
// Global and per-link transmit configuration register bank
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module t1cfg_regs
	import t1cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DW-1:0] rdata_o,
	input wire logic [MAP_W-1:0] counter_map_i,
	input wire logic [LINKS*GAP_W-1:0] pointer_gap_i,
	input wire logic [LINKS-1:0] rx_clk_slave_i,
	input wire logic [LINKS-1:0] rx_system_clock_pin_i,
	input wire logic [LINKS-1:0] rx_frame_pulse_pin_i,
	input wire logic [LINKS-1:0] tx_clk_slave_i,
	input wire logic [LINKS-1:0] tx_system_clock_pin_i,
	input wire logic [LINKS-1:0] tx_frame_pulse_pin_i,
	input wire logic tx_bus_a_data_i,
	input wire logic tx_bus_a_sig_i,
	input wire logic tx_bus_b_data_i,
	input wire logic tx_bus_b_sig_i,
	output logic [LINKS-1:0] rx_timing_clk_o,
	output logic [LINKS-1:0] rx_timing_frame_o,
	output logic [LINKS-1:0] tx_timing_clk_o,
	output logic [LINKS-1:0] tx_timing_frame_o,
	output logic rx_multiplexed_sel_o,
	output logic tx_multiplexed_sel_o,
	output logic tx_bus_choice_o,
	output logic tx_demux_data_o,
	output logic tx_demux_sig_o,
	output logic [LINKS-1:0] atten_enable_o,
	output logic [LINKS-1:0] atten_corner_sel_o,
	output logic [LINKS-1:0] atten_widen_o,
	output logic [LINKS*8-1:0] atten_depth_bits_o,
	output logic [LINKS-1:0] tx_power_down_o,
	output logic [LINKS-1:0] line_driver_hiz_o,
	output logic [LINKS-1:0] tx_line_code_sel_o,
	output logic [LINKS-1:0] driver_fault_watch_en_o,
	output logic [LINKS*4-1:0] pulse_shape_sel_o,
	output logic [LINKS*2-1:0] pulse_class_o
);
	logic [DW-1:0] win_sel_reg;
	logic [DW-1:0] backplane_reg;
	logic [DW-1:0] ja_cfg_reg [LINKS];
	logic [DW-1:0] tx_a_reg [LINKS];
	logic [DW-1:0] tx_b_reg [LINKS];
	logic [GAP_W-1:0] gap_ind [LINKS];
	logic [DW-1:0] rdata_next;
	logic [DW-1:0] win_data;
	logic [2:0] acc_link;
	logic [7:0] acc_ofs;
	logic acc_global;
	logic rx_all_shared;
	logic tx_all_shared;

	assign acc_link = addr_i[LINK_MSB:LINK_LSB];
	assign acc_ofs = addr_i[LINK_LSB-1:0];
	assign acc_global = (acc_link == 3'h0);

	t1cfg_counter_window u_window (
		.link_pick_i(win_sel_reg[WIN_LINK_MSB:WIN_LINK_LSB]),
		.index_i(win_sel_reg[WIN_IDX_MSB:0]),
		.counter_map_i(counter_map_i),
		.data_o(win_data)
	);

	// Global selection and backplane writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_sel_reg <= WIN_SEL_RST;
			backplane_reg <= BP_RST;
		end else if (wr_i && acc_global) begin
			if (acc_ofs == OFS_WIN_SEL) begin
				win_sel_reg <= wdata_i & WIN_SEL_MASK;
			end
			if (acc_ofs == OFS_BACKPLANE) begin
				backplane_reg <= wdata_i & BP_MASK;
			end
		end
	end

	// Per-link register copies
	genvar n;
	generate
		for (n = 0; n < LINKS; n++) begin : g_link
			logic hit;
			logic [3:0] pulse;
			t1cfg_pulse_e pclass;
			assign hit = wr_i && (acc_link == 3'(n));
			assign pulse = tx_b_reg[n][TXB_PULSE_MSB:0];
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ja_cfg_reg[n] <= JA_RST;
					tx_a_reg[n] <= TXA_RST;
					tx_b_reg[n] <= TXB_RST;
				end else if (hit) begin
					if (acc_ofs == OFS_JA_CFG) begin
						ja_cfg_reg[n] <= wdata_i & JA_MASK;
					end
					if (acc_ofs == OFS_TX_A) begin
						tx_a_reg[n] <= wdata_i & TXA_MASK;
					end
					if (acc_ofs == OFS_TX_B) begin
						tx_b_reg[n] <= wdata_i & TXB_MASK;
					end
				end
			end

			t1cfg_jitter_track u_track (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.gap_i(pointer_gap_i[n*GAP_W +: GAP_W]),
				.measure_mode_i(ja_cfg_reg[n][JA_MEASURE]),
				.limit_i(ja_cfg_reg[n][JA_LIMIT]),
				.depth_code_i(ja_cfg_reg[n][JA_DEPTH_MSB:JA_DEPTH_LSB]),
				.indication_o(gap_ind[n]),
				.widen_o(atten_widen_o[n]),
				.depth_bits_o(atten_depth_bits_o[n*8 +: 8])
			);

			always_comb begin
				if (pulse[3:2] == PULSE_ARB_TOP) begin
					pclass = T1CFG_PULSE_ARB;
				end else if (pulse >= PULSE_SH_FIRST &&
					pulse <= PULSE_SH_LAST) begin
					pclass = T1CFG_PULSE_SHORT;
				end else if (pulse >= PULSE_LH_FIRST &&
					pulse <= PULSE_LH_LAST) begin
					pclass = T1CFG_PULSE_LONG;
				end else begin
					pclass = T1CFG_PULSE_RESERVED;
				end
			end

			// Control outputs from flops
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					atten_enable_o[n] <= 1'b0;
					atten_corner_sel_o[n] <= 1'b0;
					tx_power_down_o[n] <= 1'b0;
					line_driver_hiz_o[n] <= 1'b1;
					tx_line_code_sel_o[n] <= 1'b0;
					driver_fault_watch_en_o[n] <= 1'b0;
					pulse_shape_sel_o[n*4 +: 4] <= 4'h0;
					pulse_class_o[n*2 +: 2] <= 2'h0;
				end else begin
					atten_enable_o[n] <= ja_cfg_reg[n][JA_EN];
					atten_corner_sel_o[n] <= ja_cfg_reg[n][JA_CORNER];
					tx_power_down_o[n] <= tx_a_reg[n][TXA_OFF];
					line_driver_hiz_o[n] <= tx_a_reg[n][TXA_OFF] |
						tx_b_reg[n][TXB_FLOAT];
					tx_line_code_sel_o[n] <= tx_a_reg[n][TXA_CODE];
					driver_fault_watch_en_o[n] <= tx_b_reg[n][TXB_WATCH] &
						~tx_a_reg[n][TXA_OFF];
					pulse_shape_sel_o[n*4 +: 4] <= pulse;
					pulse_class_o[n*2 +: 2] <= 2'(pclass);
				end
			end
		end
	endgenerate

	// Shared timing qualifiers
	assign rx_all_shared = (&rx_clk_slave_i) & backplane_reg[BP_RX_SHARED];
	assign tx_all_shared = (&tx_clk_slave_i) & backplane_reg[BP_TX_SHARED];

	// Timing pin selection
	generate
		for (n = 0; n < LINKS; n++) begin : g_timing
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					rx_timing_clk_o[n] <= 1'b0;
					rx_timing_frame_o[n] <= 1'b0;
					tx_timing_clk_o[n] <= 1'b0;
					tx_timing_frame_o[n] <= 1'b0;
				end else begin
					rx_timing_clk_o[n] <= rx_all_shared ?
						rx_system_clock_pin_i[0] : rx_system_clock_pin_i[n];
					rx_timing_frame_o[n] <= rx_all_shared ?
						rx_frame_pulse_pin_i[0] : rx_frame_pulse_pin_i[n];
					tx_timing_clk_o[n] <= tx_all_shared ?
						tx_system_clock_pin_i[0] : tx_system_clock_pin_i[n];
					tx_timing_frame_o[n] <= tx_all_shared ?
						tx_frame_pulse_pin_i[0] : tx_frame_pulse_pin_i[n];
				end
			end
		end
	endgenerate

	// System interface modes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_multiplexed_sel_o <= 1'b0;
			tx_multiplexed_sel_o <= 1'b0;
			tx_bus_choice_o <= 1'b1;
		end else begin
			rx_multiplexed_sel_o <= backplane_reg[BP_RX_MUX];
			tx_multiplexed_sel_o <= backplane_reg[BP_TX_MUX];
			tx_bus_choice_o <= backplane_reg[BP_TX_BUS];
		end
	end

	// Multiplexed bus demultiplexing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_demux_data_o <= 1'b0;
			tx_demux_sig_o <= 1'b0;
		end else if (backplane_reg[BP_TX_MUX]) begin
			if (backplane_reg[BP_TX_BUS]) begin
				tx_demux_data_o <= tx_bus_a_data_i;
				tx_demux_sig_o <= tx_bus_a_sig_i;
			end else begin
				tx_demux_data_o <= tx_bus_b_data_i;
				tx_demux_sig_o <= tx_bus_b_sig_i;
			end
		end else begin
			tx_demux_data_o <= 1'b0;
			tx_demux_sig_o <= 1'b0;
		end
	end

	// Read decode
	always_comb begin
		rdata_next = '0;
		if (acc_global) begin
			case (acc_ofs)
				OFS_WIN_SEL: rdata_next = win_sel_reg;
				OFS_WIN_DATA: rdata_next = win_data;
				OFS_BACKPLANE: rdata_next = backplane_reg;
				default: rdata_next = '0;
			endcase
		end
		case (acc_ofs)
			OFS_JA_CFG: rdata_next = ja_cfg_reg[acc_link];
			OFS_TX_A: rdata_next = tx_a_reg[acc_link];
			OFS_TX_B: rdata_next = tx_b_reg[acc_link];
			OFS_GAP_IND: rdata_next = {1'b0, gap_ind[acc_link]};
			default: begin
			end
		endcase
	end

	// Read data one cycle after strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= rdata_next;
		end else begin
			rdata_o <= '0;
		end
	end
endmodule

// ---- dv/t1cfg_regs_assertions.sv ----
// Port assertions for the configuration register bank
`timescale 1ns/100ps
module t1cfg_regs_chk
	import t1cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DW-1:0] rdata_o,
	input wire logic [LINKS-1:0] rx_clk_slave_i,
	input wire logic [LINKS-1:0] rx_system_clock_pin_i,
	input wire logic [LINKS-1:0] rx_timing_clk_o,
	input wire logic tx_bus_a_data_i,
	input wire logic rx_multiplexed_sel_o,
	input wire logic tx_multiplexed_sel_o,
	input wire logic tx_bus_choice_o,
	input wire logic tx_demux_data_o,
	input wire logic [LINKS*8-1:0] atten_depth_bits_o,
	input wire logic [LINKS-1:0] tx_power_down_o,
	input wire logic [LINKS-1:0] line_driver_hiz_o,
	input wire logic [LINKS-1:0] driver_fault_watch_en_o,
	input wire logic [LINKS*4-1:0] pulse_shape_sel_o,
	input wire logic [LINKS*2-1:0] pulse_class_o
);
	function automatic logic [1:0] cls(logic [3:0] c);
		if (c[3:2] == 2'h3) return 2'h3;
		if (c >= 4'h2 && c <= 4'h6) return 2'h1;
		if (c >= 4'h9 && c <= 4'hB) return 2'h2;
		return 2'h0;
	endfunction
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence bp_wr;
		wr_i && addr_i == 11'h010;
	endsequence
	sequence on_bus_a;
		(tx_multiplexed_sel_o && tx_bus_choice_o) [*2];
	endsequence
	AST_RD_IDLE: assert property (
		!rd_i |=> rdata_o == 8'h00) else $error("idle read data not zero");
	AST_RX_MUX: assert property (
		bp_wr |=> ##1 rx_multiplexed_sel_o == |($past(wdata_i, 2) & 8'h08))
		else $error("rx mux select wrong");
	AST_TX_MUX: assert property (
		bp_wr |=> ##1 tx_multiplexed_sel_o == |($past(wdata_i, 2) & 8'h01))
		else $error("tx mux select wrong");
	AST_BUS_SEL: assert property (
		bp_wr |=> ##1 tx_bus_choice_o == |($past(wdata_i, 2) & 8'h04))
		else $error("tx bus choice wrong");
	AST_DEMUX_A: assert property (
		on_bus_a |-> tx_demux_data_o == $past(tx_bus_a_data_i))
		else $error("demux not from bus A");
	AST_RX_OWN: assert property (
		!(&rx_clk_slave_i) |=> rx_timing_clk_o == $past(rx_system_clock_pin_i))
		else $error("rx timing not own pins");
	AST_DEPTH: assert property (
		atten_depth_bits_o[7:0] inside {8'h80, 8'h40, 8'h20})
		else $error("depth bits illegal");
	AST_OFF_HIZ: assert property (
		(tx_power_down_o & ~line_driver_hiz_o) == 8'h00)
		else $error("powered down driver not floating");
	AST_WATCH: assert property (
		(driver_fault_watch_en_o & tx_power_down_o) == 8'h00)
		else $error("fault watch on while powered down");
	AST_PULSE: assert property (
		pulse_class_o[11:10] == cls(pulse_shape_sel_o[23:20]))
		else $error("pulse class wrong");
endmodule
bind t1cfg_regs t1cfg_regs_chk i_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .rx_clk_slave_i, .rx_system_clock_pin_i,
	.rx_timing_clk_o, .tx_bus_a_data_i, .rx_multiplexed_sel_o,
	.tx_multiplexed_sel_o, .tx_bus_choice_o, .tx_demux_data_o,
	.atten_depth_bits_o, .tx_power_down_o, .line_driver_hiz_o,
	.driver_fault_watch_en_o, .pulse_shape_sel_o, .pulse_class_o);

// ---- dv/tb_top.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module tb_top;
	import t1cfg_pkg::*;
	logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic rd_seen = 1'b0;
	logic [AW-1:0] addr_i = '0;
	logic [DW-1:0] wdata_i = '0, rdata_o;
	logic [MAP_W-1:0] counter_map_i = '0;
	logic [LINKS*GAP_W-1:0] pointer_gap_i = '0;
	logic [LINKS-1:0] rx_clk_slave_i = '0, rx_system_clock_pin_i = '0,
		rx_frame_pulse_pin_i = '0, tx_clk_slave_i = '0,
		tx_system_clock_pin_i = '0, tx_frame_pulse_pin_i = '0;
	logic tx_bus_a_data_i = 1'b0, tx_bus_a_sig_i = 1'b0;
	logic tx_bus_b_data_i = 1'b0, tx_bus_b_sig_i = 1'b0;
	logic [LINKS-1:0] rx_timing_clk_o, rx_timing_frame_o, tx_timing_clk_o,
		tx_timing_frame_o, atten_enable_o, atten_corner_sel_o,
		atten_widen_o, tx_power_down_o, line_driver_hiz_o,
		tx_line_code_sel_o, driver_fault_watch_en_o;
	logic rx_multiplexed_sel_o, tx_multiplexed_sel_o, tx_bus_choice_o,
		tx_demux_data_o, tx_demux_sig_o;
	logic [LINKS*8-1:0] atten_depth_bits_o;
	logic [LINKS*4-1:0] pulse_shape_sel_o;
	logic [LINKS*2-1:0] pulse_class_o;
	logic [7:0] expq[$];
	int error_cnt = 0;
	int n_compared = 0;
	t1cfg_regs i_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .counter_map_i, .pointer_gap_i, .rx_clk_slave_i,
		.rx_system_clock_pin_i, .rx_frame_pulse_pin_i, .tx_clk_slave_i,
		.tx_system_clock_pin_i, .tx_frame_pulse_pin_i, .tx_bus_a_data_i,
		.tx_bus_a_sig_i, .tx_bus_b_data_i, .tx_bus_b_sig_i,
		.rx_timing_clk_o, .rx_timing_frame_o, .tx_timing_clk_o,
		.tx_timing_frame_o, .rx_multiplexed_sel_o, .tx_multiplexed_sel_o,
		.tx_bus_choice_o, .tx_demux_data_o, .tx_demux_sig_o,
		.atten_enable_o, .atten_corner_sel_o, .atten_widen_o,
		.atten_depth_bits_o, .tx_power_down_o, .line_driver_hiz_o,
		.tx_line_code_sel_o, .driver_fault_watch_en_o, .pulse_shape_sel_o,
		.pulse_class_o);
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chb(string nm, logic got, logic exp);
		chk(nm, {7'h00, got}, {7'h00, exp});
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(logic [10:0] a, logic [7:0] d);
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
	endtask
	task automatic rd(logic [10:0] a, logic [7:0] e);
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		addr_i <= a;
		expq.push_back(e);
		@(posedge clk_i);
	endtask
	task automatic idle(int n);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask
	function automatic logic [7:0] sh(logic [7:0] p, logic [7:0] s, logic b);
		return (&s && b) ? {8{p[0]}} : p;
	endfunction
	// Read data watcher
	always @(posedge clk_i) begin
		if (rd_seen)
			chk("rdata", rdata_o, expq.pop_front());
		rd_seen <= rd_i;
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		error_cnt++;
		conclude();
	end
	initial begin
		int i, k;
		logic [7:0] d, e;
		logic [6:0] g[8];
		logic [7:0] w;
		void'($urandom(32'h14FA4963));
		for (i = 0; i < 24; i++)
			counter_map_i[i*32 +: 32] = $urandom;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk("hiz_rst", line_driver_hiz_o, 8'hFF);
		for (i = 0; i < 8; i++) begin
			rd({i[2:0], 8'h21}, JA_RST);
			rd({i[2:0], 8'h23}, TXB_RST);
		end
		rd(11'h00E, WIN_SEL_RST);
		rd(11'h010, BP_RST);
		chb("tx_mux_rst", tx_multiplexed_sel_o, 1'b0);
		chb("rx_mux_rst", rx_multiplexed_sel_o, 1'b0);
		chb("bus_rst", tx_bus_choice_o, 1'b1);
		for (i = 0; i < 24; i++) begin
			d = 8'($urandom);
			e = i % 3 == 0 ? JA_MASK : (i % 3 == 1 ? TXA_MASK : TXB_MASK);
			wr({i[4:2], 8'h21 + 8'(i % 3)}, d);
			rd({i[4:2], 8'h21 + 8'(i % 3)}, d & e);
		end
		wr(11'h00F, 8'hFF);
		rd(11'h10E, 8'h00);
		wr(11'h00E, 8'hFF);
		rd(11'h00E, WIN_SEL_MASK);
		for (i = 0; i < 104; i++) begin
			k = i % 13;
			wr(11'h00E, {i[2:0] + 3'(i / 13) - i[2:0], 1'b0, 4'(k)});
			e = k < 12 ? counter_map_i[((i / 13) * 12 + k) * 8 +: 8] : 8'h00;
			rd(11'h00F, e);
		end
		for (i = 0; i < 64; i++) begin
			d = {3'h0, i[4:0]};
			rx_clk_slave_i <= i[5] ? 8'hFF : 8'h7F;
			tx_clk_slave_i <= i[5] ? 8'hFF : 8'hFB;
			rx_system_clock_pin_i <= 8'($urandom);
			rx_frame_pulse_pin_i <= 8'($urandom);
			tx_system_clock_pin_i <= 8'($urandom);
			tx_frame_pulse_pin_i <= 8'($urandom);
			w = 8'($urandom);
			{tx_bus_a_data_i, tx_bus_a_sig_i} <= w[1:0];
			{tx_bus_b_data_i, tx_bus_b_sig_i} <= w[3:2];
			wr(11'h010, d);
			rd(11'h010, d);
			idle(1);
			chb("rx_mux", rx_multiplexed_sel_o, d[3]);
			chb("tx_mux", tx_multiplexed_sel_o, d[0]);
			chb("bus_sel", tx_bus_choice_o, d[2]);
			e = {6'h00, d[2] ? w[1:0] : w[3:2]} & {8{d[0]}};
			chk("demux", {6'h00, tx_demux_data_o, tx_demux_sig_o}, e);
			e = sh(rx_system_clock_pin_i, rx_clk_slave_i, d[4]);
			chk("rx_clk", rx_timing_clk_o, e);
			e = sh(rx_frame_pulse_pin_i, rx_clk_slave_i, d[4]);
			chk("rx_frm", rx_timing_frame_o, e);
			e = sh(tx_system_clock_pin_i, tx_clk_slave_i, d[1]);
			chk("tx_clk", tx_timing_clk_o, e);
			e = sh(tx_frame_pulse_pin_i, tx_clk_slave_i, d[1]);
			chk("tx_frm", tx_timing_frame_o, e);
		end
		for (k = 0; k < 16; k++) begin
			wr(11'h221, 8'(k));
			idle(2);
			chb("ja_en", atten_enable_o[2], k[3]);
			chb("ja_bw", atten_corner_sel_o[2], k[0]);
			e = k[2:1] == 2'h0 ? 8'h80 : (k[2:1] == 2'h1 ? 8'h40 : 8'h20);
			chk("ja_dp", atten_depth_bits_o[23:16], e);
		end
		pointer_gap_i[20:14] <= 7'h15;
		wr(11'h221, 8'h00);
		idle(2);
		rd(11'h238, 8'h15);
		wr(11'h221, 8'h20);
		pointer_gap_i[20:14] <= 7'h33;
		idle(2);
		pointer_gap_i[20:14] <= 7'h05;
		idle(2);
		rd(11'h238, 8'h33);
		g = '{7'd4, 7'd5, 7'd124, 7'd123, 7'd2, 7'd3, 7'd30, 7'd29};
		for (i = 0; i < 8; i++) begin
			wr(11'h221, i < 4 ? 8'h10 : 8'h14);
			pointer_gap_i[20:14] <= g[i];
			idle(3);
			chb("widen", atten_widen_o[2], i[0] == 1'b0);
		end
		wr(11'h322, 8'h11);
		wr(11'h323, 8'h20);
		idle(2);
		chb("off", tx_power_down_o[3], 1'b1);
		chb("hiz_off", line_driver_hiz_o[3], 1'b1);
		chb("ami", tx_line_code_sel_o[3], 1'b1);
		chb("dfm_off", driver_fault_watch_en_o[3], 1'b0);
		wr(11'h322, 8'h00);
		idle(2);
		chb("hiz_on", line_driver_hiz_o[3], 1'b0);
		chb("b8zs", tx_line_code_sel_o[3], 1'b0);
		chb("driver_fault_watch_en", driver_fault_watch_en_o[3], 1'b1);
		wr(11'h323, 8'h10);
		idle(2);
		chb("float", line_driver_hiz_o[3], 1'b1);
		chb("path_on", tx_power_down_o[3], 1'b0);
		for (k = 0; k < 16; k++) begin
			wr(11'h523, 8'(k));
			idle(2);
			e = k >= 12 ? 8'h3 : (k >= 2 && k <= 6 ? 8'h1 :
				(k >= 9 && k <= 11 ? 8'h2 : 8'h0));
			chk("pulse", {6'h00, pulse_class_o[11:10]}, e);
			chk("pulse_sel", {4'h0, pulse_shape_sel_o[23:20]}, 8'(k));
		end
		rst_n_i <= 1'b0;
		idle(2);
		rst_n_i <= 1'b1;
		rd(11'h523, TXB_RST);
		idle(3);
		conclude();
	end
endmodule
